// ==== design/motion_data_parameter_store.sv ====
// Purpose: Motion profile table and parameter store behind an APB slave
// Assumes: motion_busy, eff_sel and the NV read port are on pclk; NV read latency one cycle
// Notes: Register writes never reach NV; common rates and configure bits also go straight to the effective copy; the NV port has no write side
// Contract
// - Sixty-four table entries, index 0 to 63, each with all motion fields.
// - Table edits become effective only once the motion has stopped.
// - Position is signed, -8388608 to +8388607, default zero.
// - Speed 0 to 1000000 Hz for all moves, default 1000.
// - Travel mode 0 relative, 1 absolute coordinate, default 0.
// - Chaining 0 single, 1 linked, 2 linked style two, default 0.
// - Accel and decel 1 to 1000000, defaults 20000 and 30000.
// - Sequential positioning flag, 0 off, 1 on, default off.
// - Dwell 0 to 50000 milliseconds, default 0.
// - Per-entry rates used when separate is selected, else common rates.
// - Unit select: rate per kHz or time; rate is the default.
// - Power-up copies NV into working memory, then sets up effective copy.
// - Four update classes: immediate, after stop, after configure, after power cycle.
// - Link writes change the working copy, and the effective copy for common rates and configure, never NV storage.
`include "motion_store_map.svh"

module motion_data_parameter_store
	import motion_store_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic motion_busy,
	input wire logic [5:0] eff_sel,
	output entry_t eff_entry,
	output logic [19:0] eff_accel,
	output logic [19:0] eff_decel,
	output logic unit_time,
	output logic [15:0] boot_param,
	output logic init_done,
	output logic nv_rd_en,
	output logic [5:0] nv_rd_addr,
	input wire entry_t nv_rd_data,
	input wire glob_t nv_glob
);

	////////////////////////////////////////////////////////////////////////////////
	// Storage

	entry_t work_mem [`MS_ENTRIES];
	entry_t eff_mem [`MS_ENTRIES];
	glob_t work_glob_r;
	glob_t eff_glob_r;
	init_state_t state_r;
	logic [5:0] index_r;
	logic [5:0] ld_idx_r;
	logic ld_vld_r;
	logic pending_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic nv_rd_en_r;
	logic [5:0] nv_rd_addr_r;
	entry_t eff_entry_r;
	logic [19:0] eff_accel_r;
	logic [19:0] eff_decel_r;
	logic init_done_r;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	wire run = (state_r == ST_RUN);
	wire access = psel & penable & ~pready_r & run;
	wire xfer = psel & penable & pready_r;
	wire wr = xfer & pwrite & ~pslverr_r;
	wire a_ctrl = (paddr == `MS_OFF_CTRL);
	wire a_stat = (paddr == `MS_OFF_STATUS);
	wire a_idx = (paddr == `MS_OFF_INDEX);
	wire a_pos = (paddr == `MS_OFF_POS);
	wire a_spd = (paddr == `MS_OFF_SPEED);
	wire a_mode = (paddr == `MS_OFF_MODE);
	wire a_func = (paddr == `MS_OFF_FUNC);
	wire a_acc = (paddr == `MS_OFF_ACCEL);
	wire a_dec = (paddr == `MS_OFF_DECEL);
	wire a_seq = (paddr == `MS_OFF_SEQ);
	wire a_dwl = (paddr == `MS_OFF_DWELL);
	wire a_cacc = (paddr == `MS_OFF_CACCEL);
	wire a_cdec = (paddr == `MS_OFF_CDECEL);
	wire a_boot = (paddr == `MS_OFF_BOOT);
	wire a_field = a_pos | a_spd | a_mode | a_func | a_acc | a_dec | a_seq | a_dwl;
	wire a_any = a_ctrl | a_stat | a_idx | a_field | a_cacc | a_cdec | a_boot;

	////////////////////////////////////////////////////////////////////////////////
	// Range checks; out-of-range writes are refused with pslverr and change nothing

	wire pos_ok = (pwdata[31:23] == 9'h000) | (pwdata[31:23] == 9'h1FF);
	wire spd_ok = (pwdata <= `MS_RATE_MAX);
	wire bit_ok = (pwdata[31:1] == 31'h00000000);
	wire func_ok = (pwdata <= `MS_FUNC_MAX);
	wire rate_ok = (pwdata != 32'h00000000) & (pwdata <= `MS_RATE_MAX);
	wire dwl_ok = (pwdata <= `MS_DWELL_MAX);
	wire boot_ok = (pwdata[31:16] == 16'h0000);

	wire val_ok = a_pos ? pos_ok :
		a_spd ? spd_ok :
		(a_mode | a_seq) ? bit_ok :
		a_func ? func_ok :
		(a_acc | a_dec | a_cacc | a_cdec) ? rate_ok :
		a_dwl ? dwl_ok :
		a_boot ? boot_ok : 1'b1;
	wire err_nxt = ~a_any | (pwrite & (a_stat | ~val_ok));

	wire cfg_cmd = wr & a_ctrl & pwdata[`MS_CTRL_CONFIG];
	wire def_cmd = wr & a_ctrl & pwdata[`MS_CTRL_DEFAULT];
	wire field_wr = (wr & a_field) | def_cmd;

	////////////////////////////////////////////////////////////////////////////////
	// Modified entry for a field write

	entry_t cur_entry;
	entry_t def_entry;
	entry_t new_entry;
	assign cur_entry = work_mem[index_r];
	assign def_entry = '{pos: `MS_POS_RST, speed: `MS_SPEED_RST,
		fixed_coordinate_target: `MS_MODE_RST, chain: `MS_FUNC_RST,
		accel: `MS_ACCEL_RST, decel: `MS_DECEL_RST,
		seq_en: `MS_SEQ_RST, dwell: `MS_DWELL_RST};

	always_comb begin
		new_entry = cur_entry;
		if (def_cmd) begin
			new_entry = def_entry;
		end else if (a_pos) begin
			new_entry.pos = pwdata[23:0];
		end else if (a_spd) begin
			new_entry.speed = pwdata[19:0];
		end else if (a_mode) begin
			new_entry.fixed_coordinate_target = pwdata[0];
		end else if (a_func) begin
			new_entry.chain = pwdata[1:0];
		end else if (a_acc) begin
			new_entry.accel = pwdata[19:0];
		end else if (a_dec) begin
			new_entry.decel = pwdata[19:0];
		end else if (a_seq) begin
			new_entry.seq_en = pwdata[0];
		end else if (a_dwl) begin
			new_entry.dwell = pwdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux

	logic [31:0] rd_mux;
	wire glob_diff = (work_glob_r.rate_common != eff_glob_r.rate_common) |
		(work_glob_r.unit_time != eff_glob_r.unit_time);
	always_comb begin
		rd_mux = 32'h00000000;
		if (a_ctrl) begin
			rd_mux[`MS_CTRL_COMMON] = work_glob_r.rate_common;
			rd_mux[`MS_CTRL_UNIT_TIME] = work_glob_r.unit_time;
		end else if (a_stat) begin
			rd_mux[`MS_ST_PENDING] = pending_r;
			rd_mux[`MS_ST_INIT_DONE] = run;
			rd_mux[`MS_ST_BUSY] = motion_busy;
			rd_mux[`MS_ST_CFG_DIFF] = glob_diff;
		end else if (a_idx) begin
			rd_mux[5:0] = index_r;
		end else if (a_pos) begin
			rd_mux = {{8{cur_entry.pos[23]}}, cur_entry.pos};
		end else if (a_spd) begin
			rd_mux[19:0] = cur_entry.speed;
		end else if (a_mode) begin
			rd_mux[0] = cur_entry.fixed_coordinate_target;
		end else if (a_func) begin
			rd_mux[1:0] = cur_entry.chain;
		end else if (a_acc) begin
			rd_mux[19:0] = cur_entry.accel;
		end else if (a_dec) begin
			rd_mux[19:0] = cur_entry.decel;
		end else if (a_seq) begin
			rd_mux[0] = cur_entry.seq_en;
		end else if (a_dwl) begin
			rd_mux[15:0] = cur_entry.dwell;
		end else if (a_cacc) begin
			rd_mux[19:0] = eff_glob_r.common_accel;
		end else if (a_cdec) begin
			rd_mux[19:0] = eff_glob_r.common_decel;
		end else if (a_boot) begin
			rd_mux[15:0] = work_glob_r.boot_param;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Start-up sequence and apply conditions

	wire ld_last = ld_vld_r & (ld_idx_r == `MS_LAST_IDX);
	// Apply waits for standstill so a running profile never sees a half-edited entry
	wire stop_apply = run & pending_r & ~motion_busy;
	wire bulk_copy = (state_r == ST_CALC) | stop_apply | (cfg_cmd & ~motion_busy);
	// A write in the apply cycle keeps pending set: the set wins over the clear
	wire pending_nxt = field_wr | (pending_r & ~bulk_copy);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_LOAD;
			nv_rd_en_r <= 1'b1;
			nv_rd_addr_r <= 6'h00;
			ld_vld_r <= 1'b0;
			ld_idx_r <= 6'h00;
			init_done_r <= 1'b0;
		end else begin
			ld_vld_r <= nv_rd_en_r;
			ld_idx_r <= nv_rd_addr_r;
			init_done_r <= (state_r != ST_LOAD);
			unique case (state_r)
				ST_LOAD: begin
					nv_rd_en_r <= nv_rd_en_r & (nv_rd_addr_r != `MS_LAST_IDX);
					nv_rd_addr_r <= nv_rd_addr_r + 6'h01;
					if (ld_last) begin
						state_r <= ST_CALC;
					end
				end
				ST_CALC: state_r <= ST_RUN;
				ST_RUN: state_r <= ST_RUN;
			endcase
		end
	end

	// Entry arrays carry no reset; the load from NV fills them before any use
	always_ff @(posedge pclk) begin
		if (ld_vld_r) begin
			work_mem[ld_idx_r] <= nv_rd_data;
		end else if (field_wr) begin
			work_mem[index_r] <= new_entry;
		end
		if (bulk_copy) begin
			eff_mem <= work_mem;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Global parameters and their update classes

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			work_glob_r <= '{`MS_CACCEL_RST, `MS_CDECEL_RST, 1'b0, 1'b0, 16'h0000};
			eff_glob_r <= '{`MS_CACCEL_RST, `MS_CDECEL_RST, 1'b0, 1'b0, 16'h0000};
			index_r <= 6'h00;
			pending_r <= 1'b0;
		end else begin
			pending_r <= pending_nxt;
			if (ld_last) begin
				work_glob_r <= nv_glob;
				eff_glob_r <= nv_glob;
			end else begin
				if (wr & a_idx) begin
					index_r <= pwdata[5:0];
				end
				if (wr & a_ctrl) begin
					work_glob_r.rate_common <= pwdata[`MS_CTRL_COMMON];
					work_glob_r.unit_time <= pwdata[`MS_CTRL_UNIT_TIME];
				end
				if (wr & a_cacc) begin
					work_glob_r.common_accel <= pwdata[19:0];
					eff_glob_r.common_accel <= pwdata[19:0];
				end
				if (wr & a_cdec) begin
					work_glob_r.common_decel <= pwdata[19:0];
					eff_glob_r.common_decel <= pwdata[19:0];
				end
				if (wr & a_boot) begin
					work_glob_r.boot_param <= pwdata[15:0];
				end
				if (cfg_cmd) begin
					// Configure takes the staged bits from this same write
					eff_glob_r.rate_common <= pwdata[`MS_CTRL_COMMON];
					eff_glob_r.unit_time <= pwdata[`MS_CTRL_UNIT_TIME];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB answer: one wait state, everything registered

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= access;
			pslverr_r <= access & err_nxt;
			if (access) begin
				prdata_r <= (pwrite | err_nxt) ? 32'h00000000 : rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Effective view for the motion engine

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eff_entry_r <= '0;
			eff_accel_r <= `MS_ACCEL_RST;
			eff_decel_r <= `MS_DECEL_RST;
		end else begin
			eff_entry_r <= eff_mem[eff_sel];
			// Common rates are live the moment they are written
			eff_accel_r <= eff_glob_r.rate_common ? eff_glob_r.common_accel :
				eff_mem[eff_sel].accel;
			eff_decel_r <= eff_glob_r.rate_common ? eff_glob_r.common_decel :
				eff_mem[eff_sel].decel;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign eff_entry = eff_entry_r;
	assign eff_accel = eff_accel_r;
	assign eff_decel = eff_decel_r;
	assign unit_time = eff_glob_r.unit_time;
	assign boot_param = eff_glob_r.boot_param;
	assign init_done = init_done_r;
	assign nv_rd_en = nv_rd_en_r;
	assign nv_rd_addr = nv_rd_addr_r;

endmodule : motion_data_parameter_store

// ==== design/motion_store_map.svh ====
// Purpose: Offsets, field positions, reset values and limits of the motion store
// Assumes: Byte addresses on a 32-bit APB, one aligned word per register
// Notes: Definitions only
`ifndef MOTION_STORE_MAP_SVH
`define MOTION_STORE_MAP_SVH

`define MS_ENTRIES 64
`define MS_LAST_IDX 6'h3F

`define MS_OFF_CTRL 12'h000
`define MS_OFF_STATUS 12'h004
`define MS_OFF_INDEX 12'h008
`define MS_OFF_POS 12'h010
`define MS_OFF_SPEED 12'h014
`define MS_OFF_MODE 12'h018
`define MS_OFF_FUNC 12'h01C
`define MS_OFF_ACCEL 12'h020
`define MS_OFF_DECEL 12'h024
`define MS_OFF_SEQ 12'h028
`define MS_OFF_DWELL 12'h02C
`define MS_OFF_CACCEL 12'h030
`define MS_OFF_CDECEL 12'h034
`define MS_OFF_BOOT 12'h038

`define MS_CTRL_COMMON 0
`define MS_CTRL_UNIT_TIME 1
`define MS_CTRL_CONFIG 2
`define MS_CTRL_DEFAULT 3

`define MS_ST_PENDING 0
`define MS_ST_INIT_DONE 1
`define MS_ST_BUSY 2
`define MS_ST_CFG_DIFF 3

`define MS_POS_RST 24'h000000
`define MS_SPEED_RST 20'h003E8
`define MS_MODE_RST 1'h0
`define MS_FUNC_RST 2'h0
`define MS_ACCEL_RST 20'h04E20
`define MS_DECEL_RST 20'h07530
`define MS_SEQ_RST 1'h0
`define MS_DWELL_RST 16'h0000
`define MS_CACCEL_RST 20'h07530
`define MS_CDECEL_RST 20'h07530

`define MS_RATE_MAX 32'h000F4240
`define MS_FUNC_MAX 32'h00000002
`define MS_DWELL_MAX 32'h0000C350

`endif

// ==== design/motion_store_pkg.sv ====
// Purpose: Types shared by the motion store
// Assumes: Field widths cover the documented ranges
// Notes: Speed and rates need 20 bits for values up to one million
package motion_store_pkg;

	typedef struct packed {
		logic signed [23:0] pos;
		logic [19:0] speed;
		logic fixed_coordinate_target;
		logic [1:0] chain;
		logic [19:0] accel;
		logic [19:0] decel;
		logic seq_en;
		logic [15:0] dwell;
	} entry_t;

	typedef struct packed {
		logic [19:0] common_accel;
		logic [19:0] common_decel;
		logic rate_common;
		logic unit_time;
		logic [15:0] boot_param;
	} glob_t;

	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_CALC = 2'b01,
		ST_RUN = 2'b10
	} init_state_t;

endpackage : motion_store_pkg

// ==== dv/motion_data_parameter_store_bench.sv ====
// Purpose: Self-checking bench for the motion store
// Assumes: NV model loads address-derived entries
// Notes: Bus answers are checked in order by a separate monitor
`include "motion_store_map.svh"
module motion_data_parameter_store_bench import motion_store_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, motion_busy, pready, pslverr;
	logic unit_time, init_done, nv_rd_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0] eff_sel, nv_rd_addr, idx;
	entry_t eff_entry, nv_rd_data;
	glob_t nv_glob;
	logic [19:0] eff_accel, eff_decel;
	logic [15:0] boot_param;
	logic [64:0] notes [$];
	logic [64:0] n;
	int failures, n_checks, seed, i;
	logic [31:0] maxv [8] = '{32'h7FFFFF, 32'hF4240, 32'h1, 32'h2,
		32'hF4240, 32'hF4240, 32'h1, 32'hC350};
	logic [31:0] badv [8] = '{32'h800000, 32'hF4241, 32'h2, 32'h3,
		32'h0, 32'hF4241, 32'h2, 32'hC351};
	logic [31:0] defv [8] = '{32'h0, 32'h3E8, 32'h0, 32'h0, 32'h4E20, 32'h7530, 32'h0, 32'h0};
	////////////////////////////////////////////////////////////////////////////////
	motion_data_parameter_store uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .motion_busy, .eff_sel, .eff_entry, .eff_accel,
		.eff_decel, .unit_time, .boot_param, .init_done, .nv_rd_en, .nv_rd_addr, .nv_rd_data,
		.nv_glob);
	nv_store_model nv (.pclk, .nv_rd_en, .nv_rd_addr, .nv_rd_data, .nv_glob);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task complete_run;
		$display("failures %0d checks %0d", failures, n_checks);
		if (failures == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	task chk(input logic ok);
		n_checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("ERROR %0t port value mismatch", $time);
		end
	endtask : chk
	// Expectation queued first, request held until pready is sampled
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e,
		input logic [31:0] x, input logic [31:0] m);
		notes.push_back({e, x, m});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d, e, 32'h0, 32'hFFFFFFFF);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
		apb(1'b0, a, 32'h0, 1'b0, x, m);
	endtask : rd
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			n = (notes.size() > 0) ? notes.pop_front() : {1'b1, 64'h0};
			n_checks++;
			if (pslverr !== n[64] || ((prdata ^ n[63:32]) & n[31:0]) !== 32'h0) begin
				failures++;
				$display("ERROR %0t bus answer mismatch", $time);
			end
		end
	end
	initial begin
		repeat (6000) @(posedge pclk);
		failures++;
		complete_run();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, motion_busy, presetn} = '0;
		paddr = 12'h000;
		pwdata = 32'h0;
		eff_sel = 6'h00;
		seed = 32'he4ad7541;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(`MS_OFF_STATUS, 32'h2, 32'h6);
		chk(nv_rd_en === 1'b0 && boot_param === 16'h1234);
		for (i = 0; i < 8; i++) begin
			idx = (i == 0) ? 6'h00 : (i == 1) ? `MS_LAST_IDX : 6'($random(seed));
			wr(`MS_OFF_INDEX, 32'(idx), 1'b0);
			rd(`MS_OFF_POS, 32'(idx) - 32'h20, 32'hFFFFFFFF);
			rd(`MS_OFF_DWELL, 32'(idx), 32'hFFFFFFFF);
		end
		eff_sel <= 6'h09;
		repeat (2) @(posedge pclk);
		chk(eff_entry.pos === 24'hFFFFE9);
		motion_busy <= 1'b1;
		wr(`MS_OFF_INDEX, 32'h9, 1'b0);
		wr(`MS_OFF_POS, 32'hFF800000, 1'b0);
		rd(`MS_OFF_POS, 32'hFF800000, 32'hFFFFFFFF);
		for (i = 0; i < 8; i++) begin
			wr(12'h010 + 12'(4 * i), maxv[i], 1'b0);
			wr(12'h010 + 12'(4 * i), badv[i], 1'b1);
			rd(12'h010 + 12'(4 * i), maxv[i], 32'hFFFFFFFF);
		end
		chk(eff_entry.speed === 20'h00009);
		rd(`MS_OFF_STATUS, 32'h5, 32'h5);
		motion_busy <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(eff_entry.speed === 20'hF4240);
		wr(`MS_OFF_CTRL, 32'h8, 1'b0);
		for (i = 0; i < 8; i++) begin
			rd(12'h010 + 12'(4 * i), defv[i], 32'hFFFFFFFF);
		end
		wr(`MS_OFF_CACCEL, 32'h309, 1'b0);
		wr(`MS_OFF_CDECEL, 32'h30A, 1'b0);
		wr(`MS_OFF_CTRL, 32'h5, 1'b0);
		repeat (2) @(posedge pclk);
		chk(eff_accel === 20'h00309 && eff_decel === 20'h0030A);
		wr(`MS_OFF_CTRL, 32'h2, 1'b0);
		rd(`MS_OFF_STATUS, 32'h8, 32'h8);
		chk(unit_time === 1'b0 && eff_accel === 20'h00309);
		wr(`MS_OFF_CTRL, 32'h6, 1'b0);
		repeat (2) @(posedge pclk);
		chk(unit_time === 1'b1 && eff_accel === 20'h04E20 && eff_decel === 20'h07530);
		wr(`MS_OFF_BOOT, 32'h55, 1'b0);
		rd(`MS_OFF_BOOT, 32'h55, 32'hFFFFFFFF);
		chk(boot_param === 16'h1234);
		wr(12'h0FC, 32'h1, 1'b1);
		apb(1'b0, 12'h0FC, 32'h0, 1'b1, 32'h0, 32'hFFFFFFFF);
		wr(`MS_OFF_STATUS, 32'h1, 1'b1);
		repeat (2) @(posedge pclk);
		chk(notes.size() == 0);
		complete_run();
	end
endmodule : motion_data_parameter_store_bench
bind motion_data_parameter_store motion_store_properties props (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .motion_busy, .eff_sel, .eff_entry,
	.unit_time, .boot_param, .init_done, .nv_rd_en, .nv_rd_addr);

// ==== dv/motion_store_properties.sv ====
// Purpose: Port-level timing checks of the motion store
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound from the bench top file
`include "motion_store_map.svh"
module motion_store_properties
	import motion_store_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic motion_busy,
	input wire logic [5:0] eff_sel,
	input wire entry_t eff_entry,
	input wire logic unit_time,
	input wire logic [15:0] boot_param,
	input wire logic init_done,
	input wire logic nv_rd_en,
	input wire logic [5:0] nv_rd_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////////
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready high two cycles");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_NO_READY_BEFORE_INIT: assert property (pready |-> $past(init_done))
		else $error("answer before start-up done");
	AST_NV_ADDR_STEP: assert property (
		nv_rd_en && nv_rd_addr != 6'h00 |-> $past(nv_rd_addr) == nv_rd_addr - 6'h01)
		else $error("NV load address skipped");
	AST_INIT_AFTER_LOAD: assert property (init_done |-> !nv_rd_en)
		else $error("running while NV load active");
	AST_ZERO_ON_WRITE: assert property (
		pready && (pwrite || pslverr) |-> prdata == 32'h00000000)
		else $error("read data not zero on write or error");
	// Frozen only when the motion engine keeps looking at the same entry
	// A copy shows on the port two edges after it, so busy is taken two cycles back
	AST_EFF_FROZEN_BUSY: assert property (
		init_done && $past(init_done, 2) && $past(motion_busy, 2)
		&& $past(eff_sel) == $past(eff_sel, 2) |-> $stable(eff_entry))
		else $error("effective entry changed while moving");
	AST_UNIT_ON_CONFIG: assert property (
		init_done && $past(init_done) && $changed(unit_time) |-> $past(pready) && $past(psel)
		&& $past(pwrite) && $past(paddr) == `MS_OFF_CTRL)
		else $error("unit changed without configure write");
	AST_BOOT_STABLE: assert property (
		init_done && $past(init_done) |-> $stable(boot_param))
		else $error("power-cycle parameter changed in run");
endmodule : motion_store_properties

// ==== dv/nv_store_model.sv ====
// Purpose: Non-volatile store answering the start-up load
// Assumes: Read latency of one clock
// Notes: No write side, so bus writes can never reach it
module nv_store_model
	import motion_store_pkg::*;
(
	input wire logic pclk,
	input wire logic nv_rd_en,
	input wire logic [5:0] nv_rd_addr,
	output entry_t nv_rd_data,
	output glob_t nv_glob
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////////
	assign nv_glob = '{20'h001F4, 20'h00258, 1'b0, 1'b0, 16'h1234};
	// Content derived from the address so every entry differs
	always @(posedge pclk) begin
		if (nv_rd_en) begin
			nv_rd_data <= '{24'(nv_rd_addr) - 24'h000020, 20'(nv_rd_addr), nv_rd_addr[0],
				2'(nv_rd_addr % 6'h03), 20'(nv_rd_addr) + 20'h00001,
				20'(nv_rd_addr) + 20'h00002, nv_rd_addr[1], 16'(nv_rd_addr)};
		end else begin
			// Idle output toggles so a late sample cannot look valid
			nv_rd_data <= ~nv_rd_data;
		end
	end
endmodule : nv_store_model
